/* File: rtl/ssc_core.sv */
// Execution unit for skip, bit, branch, call/return and system-control instructions
`timescale 1ns/1ps
module ssc_core
	import ssc_pkg::*;
(
	input  wire logic                               clk,
	input  wire logic                               rst,
	input  wire ssc_pkg::ssc_instr_t                instr,
	input  wire logic [ssc_pkg::IO_NUM-1:0][7:0]    io_regs,
	input  wire logic                               wake_pin,
	output logic [ssc_pkg::PC_W-1:0]                pc_r,
	output logic [ssc_pkg::DATA_W-1:0]              acc_r,
	output ssc_pkg::ssc_flags_t                     flags_r,
	output logic [ssc_pkg::SP_W-1:0]                sp_r,
	output logic                                    gie_r,
	output logic                                    sys_halt_r,
	output logic                                    cpu_halt_r,
	output logic                                    osc_run_r,
	output logic                                    chip_reset_req_r,
	output logic                                    wdt_clear_r
);
	import ssc_pkg::*;

	typedef enum logic [2:0] {st_exec, st_second, st_sys_halt, st_cpu_halt, st_reset_wait}
		ssc_state_t;

	logic [DATA_W-1:0]   dmem [DMEM_DEPTH];
	ssc_state_t          state_r, state_nxt;
	ssc_pend_t           pend_r, pend_nxt;
	logic [RET_HI_W-1:0] ret_hi_r, ret_hi_nxt;
	logic [PC_W-1:0]     pc_nxt;
	logic [DATA_W-1:0]   acc_nxt;
	ssc_flags_t          flags_nxt;
	logic [SP_W-1:0]     sp_nxt;
	logic                gie_nxt;
	logic                mem_we;
	logic [DADDR_W-1:0]  mem_wa;
	logic [DATA_W-1:0]   mem_wd;
	logic                wake_m_r, wake_s_r;
	logic                skip_r;

	// Operand selection and condition decoding
	wire                in_exec   = (state_r == st_exec);
	wire [DADDR_W-1:0]  bit_addr  = {1'b0, instr.maddr[BIT_ADDR_W-1:0]};
	wire [DATA_W-1:0]   mem_byte  = dmem[instr.maddr];
	wire [DATA_W-1:0]   bit_byte  = dmem[bit_addr];
	wire [DATA_W-1:0]   io_byte   = io_regs[instr.ioaddr];
	wire                io_bit    = io_byte[instr.bitn];
	wire                m_bit     = bit_byte[instr.bitn];
	wire [DATA_W-1:0]   operand   = instr.use_mem ? mem_byte : instr.imm;
	wire [DATA_W-1:0]   step_src  = instr.use_mem ? mem_byte : acc_r;
	wire ssc_alu_t      cmp_res   = ssc_arith(acc_r, operand, 1'b1);
	wire ssc_alu_t      inc_res   = ssc_arith(step_src, BYTE_ONE, 1'b0);
	wire ssc_alu_t      dec_res   = ssc_arith(step_src, BYTE_ONE, 1'b1);
	wire [PC_W-1:0]     pc_inc    = pc_r + PC_ONE;
	wire [SP_W-1:0]     sp_back   = sp_r - SP_STEP;
	wire [SP_W-1:0]     sp_back_h = sp_r - SP_ONE;
	wire [SP_W-1:0]     sp_up_h   = sp_r + SP_ONE;
	wire [DATA_W-1:0]   ret_hi_b  = dmem[sp_back_h[DADDR_W-1:0]];
	wire [PC_W-1:0]     ret_addr  = {ret_hi_b[RET_HI_W-1:0], dmem[sp_back[DADDR_W-1:0]]};
	wire [PC_W-1:0]     pc_plus_a = pc_r + {{RET_HI_W{1'b0}}, acc_r};

	// Only a taken skip steps pc again in its dropped slot; branch bubbles keep the target
	wire                is_skip_op = instr.op inside {op_cmp_eq, op_cmp_ne, op_test_low_skip_io,
		op_test_high_skip_io, op_test_low_skip_m, op_test_high_skip_m, op_inc_skip_zero,
		op_dec_skip_zero};
	wire                skip_nxt   = in_exec && (state_nxt == st_second) && is_skip_op;

	// Next-state decode; any taken skip or two-cycle op passes through st_second
	always_comb begin
		state_nxt  = state_r;
		pend_nxt   = pend_none;
		ret_hi_nxt = ret_hi_r;
		pc_nxt     = pc_r;
		acc_nxt    = acc_r;
		flags_nxt  = flags_r;
		sp_nxt     = sp_r;
		gie_nxt    = gie_r;
		mem_we     = 1'b0;
		mem_wa     = instr.maddr;
		mem_wd     = BYTE_ZERO;
		unique case (state_r)
			st_exec: begin
				pc_nxt = pc_inc;
				unique case (instr.op)
					op_bit_clear_op: begin
						mem_we = 1'b1;
						mem_wa = bit_addr;
						mem_wd = bit_byte & ~ssc_bit_mask(instr.bitn);
					end
					op_bit_force_high_op: begin
						mem_we = 1'b1;
						mem_wa = bit_addr;
						mem_wd = bit_byte | ssc_bit_mask(instr.bitn);
					end
					op_cmp_eq: begin
						flags_nxt = cmp_res.fl;
						if (cmp_res.res == BYTE_ZERO) state_nxt = st_second;
					end
					op_cmp_ne: begin
						flags_nxt = cmp_res.fl;
						if (cmp_res.res != BYTE_ZERO) state_nxt = st_second;
					end
					op_test_low_skip_io:  if (!io_bit) state_nxt = st_second;
					op_test_high_skip_io: if (io_bit) state_nxt = st_second;
					op_test_low_skip_m:   if (!m_bit) state_nxt = st_second;
					op_test_high_skip_m:  if (m_bit) state_nxt = st_second;
					op_inc_skip_zero: begin
						flags_nxt = inc_res.fl;
						if (instr.use_mem) begin
							mem_we = 1'b1;
							mem_wd = inc_res.res;
						end else begin
							acc_nxt = inc_res.res;
						end
						if (inc_res.fl.z) state_nxt = st_second;
					end
					op_dec_skip_zero: begin
						flags_nxt = dec_res.fl;
						if (instr.use_mem) begin
							mem_we = 1'b1;
							mem_wd = dec_res.res;
						end else begin
							acc_nxt = dec_res.res;
						end
						if (dec_res.fl.z) state_nxt = st_second;
					end
					op_call: begin
						// Low byte now, high byte next cycle: the RAM has one write port
						mem_we     = 1'b1;
						mem_wa     = sp_r[DADDR_W-1:0];
						mem_wd     = pc_inc[DATA_W-1:0];
						ret_hi_nxt = pc_inc[PC_W-1:DATA_W];
						pc_nxt     = instr.target;
						pend_nxt   = pend_call_hi;
						state_nxt  = st_second;
					end
					op_jump: begin
						pc_nxt    = instr.target;
						state_nxt = st_second;
					end
					op_ret_value, op_ret, op_ret_int: begin
						if (instr.op == op_ret_value) acc_nxt = instr.imm;
						sp_nxt    = sp_back;
						pc_nxt    = ret_addr;
						if (instr.op == op_ret_int) pend_nxt = pend_ret_int;
						state_nxt = st_second;
					end
					op_pc_add: begin
						pc_nxt    = pc_plus_a;
						state_nxt = st_second;
					end
					op_gie_on:     gie_nxt = 1'b1;
					op_gie_off:    gie_nxt = 1'b0;
					op_sys_stop:   state_nxt = st_sys_halt;
					op_cpu_stop:   state_nxt = st_cpu_halt;
					op_soft_reset: state_nxt = st_reset_wait;
					op_index_move: state_nxt = st_second;
					default: ;
				endcase
			end
			st_second: begin
				// Fetched word here is always dropped; this slot finishes a call or an interrupt return, or steps pc after a taken skip
				state_nxt = st_exec;
				if (pend_r == pend_call_hi) begin
					mem_we = 1'b1;
					mem_wa = sp_up_h[DADDR_W-1:0];
					mem_wd = {{(DATA_W-RET_HI_W){1'b0}}, ret_hi_r};
					sp_nxt = sp_r + SP_STEP;
				end
				if (pend_r == pend_ret_int) gie_nxt = 1'b1;
				if (pend_r == pend_none && skip_r) pc_nxt = pc_inc;
			end
			st_sys_halt, st_cpu_halt: if (wake_s_r) state_nxt = st_exec;
			st_reset_wait: ; // Held until the chip reset lands
			default: state_nxt = st_exec;
		endcase
	end

	// Wake pin is asynchronous; only the second stage is read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wake_m_r <= 1'b0;
			wake_s_r <= 1'b0;
		end else begin
			wake_m_r <= wake_pin;
			wake_s_r <= wake_m_r;
		end
	end

	// Data RAM holds the stack and bit-addressable bytes; no reset on contents
	always_ff @(posedge clk) begin
		if (mem_we) dmem[mem_wa] <= mem_wd;
	end

	// Core state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r  <= st_exec;
			pend_r   <= pend_none;
			ret_hi_r <= '0;
			pc_r     <= PC_RST;
			acc_r    <= BYTE_ZERO;
			flags_r  <= '0;
			sp_r     <= SP_RST;
			gie_r    <= 1'b0;
			skip_r   <= 1'b0;
		end else begin
			state_r  <= state_nxt;
			pend_r   <= pend_nxt;
			ret_hi_r <= ret_hi_nxt;
			pc_r     <= pc_nxt;
			acc_r    <= acc_nxt;
			flags_r  <= flags_nxt;
			sp_r     <= sp_nxt;
			gie_r    <= gie_nxt;
			skip_r   <= skip_nxt;
		end
	end

	// Clock and reset controls to the system; reset request asks for a full chip reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sys_halt_r       <= 1'b0;
			cpu_halt_r       <= 1'b0;
			osc_run_r        <= 1'b1;
			chip_reset_req_r <= 1'b0;
			wdt_clear_r      <= 1'b0;
		end else begin
			sys_halt_r       <= (state_nxt == st_sys_halt);
			cpu_halt_r       <= (state_nxt == st_cpu_halt) || (state_nxt == st_sys_halt);
			osc_run_r        <= (state_nxt != st_sys_halt);
			chip_reset_req_r <= (state_nxt == st_reset_wait);
			wdt_clear_r      <= in_exec && (instr.op == op_wdt_clear);
		end
	end

	bit_clear_write_a: assert property (
		@(posedge clk) disable iff (rst)
		(in_exec && instr.op == op_bit_clear_op) |->
			mem_we && mem_wa == bit_addr && !mem_wd[instr.bitn] ##1 $stable(flags_r))
		else $error("bit clear wrote wrong bit or changed flags");

	eq_skip_taken_a: assert property (
		@(posedge clk) disable iff (rst)
		(in_exec && instr.op == op_cmp_eq && acc_r == operand) |=>
			state_r == st_second && $stable(acc_r) && flags_r.z)
		else $error("equal compare did not skip");

	ne_keeps_acc_a: assert property (
		@(posedge clk) disable iff (rst)
		(in_exec && instr.op == op_cmp_ne) |=> $stable(acc_r) && (flags_r.z || state_r == st_second))
		else $error("not-equal compare lost accumulator or skip");

	io_low_skip_a: assert property (
		@(posedge clk) disable iff (rst)
		(in_exec && instr.op == op_test_low_skip_io && !io_bit) |=>
			state_r == st_second && $stable(flags_r))
		else $error("io low test did not skip");

	mem_high_skip_a: assert property (
		@(posedge clk) disable iff (rst)
		(in_exec && instr.op == op_test_high_skip_m && !m_bit) |=> state_r == st_exec)
		else $error("memory high test skipped on low bit");

	inc_wrap_skip_a: assert property (
		@(posedge clk) disable iff (rst)
		(in_exec && instr.op == op_inc_skip_zero && !instr.use_mem && acc_r == BYTE_FULL) |=>
			acc_r == BYTE_ZERO && state_r == st_second ##1 state_r == st_exec)
		else $error("increment wrap did not skip once");

	call_sp_step_a: assert property (
		@(posedge clk) disable iff (rst)
		(in_exec && instr.op == op_call) |=> ##1 sp_r == $past(sp_r, 2) + SP_STEP)
		else $error("call did not advance stack pointer by two");

	ret_sp_step_a: assert property (
		@(posedge clk) disable iff (rst)
		(in_exec && instr.op == op_ret) |=> sp_r == $past(sp_r) - SP_STEP && $stable(flags_r))
		else $error("return did not drop stack pointer by two");

	reti_gie_set_a: assert property (
		@(posedge clk) disable iff (rst)
		(in_exec && instr.op == op_ret_int) |=> ##1 gie_r)
		else $error("interrupt return left global enable off");

	skip_no_effect_a: assert property (
		@(posedge clk) disable iff (rst)
		(state_r == st_second && pend_r == pend_none) |->
			!mem_we ##1 $stable(acc_r) && $stable(flags_r) && $stable(sp_r))
		else $error("discarded instruction had a side effect");

	jump_target_hold_a: assert property (
		@(posedge clk) disable iff (rst)
		(in_exec && instr.op == op_jump) |=>
			pc_r == $past(instr.target) ##1 $stable(pc_r) && $stable(flags_r))
		else $error("jump did not land on its target");

	pc_add_sum_a: assert property (
		@(posedge clk) disable iff (rst)
		(in_exec && instr.op == op_pc_add) |=>
			pc_r == $past(pc_r) + PC_W'($past(acc_r)) ##1 $stable(pc_r))
		else $error("computed jump landed off pc plus accumulator");

	idx_move_two_a: assert property (
		@(posedge clk) disable iff (rst)
		(in_exec && instr.op == op_index_move) |=>
			state_r == st_second ##1 state_r == st_exec && pc_r == $past(pc_r, 2) + PC_ONE)
		else $error("index move did not take two cycles");

	wdt_pulse_a: assert property (
		@(posedge clk) disable iff (rst)
		(in_exec && instr.op == op_wdt_clear) |=> wdt_clear_r && $stable(flags_r))
		else $error("watchdog clear missed its pulse or changed flags");
endmodule

/* File: rtl/ssc_pkg.sv */
// Constants, types and helpers shared by the skip/branch/system-control execution unit
// Notes on behaviour
// - Bit clear/force touches only bit n, flags kept
// - Equal compare: flags of subtract, skip if equal
// - Not-equal compare: flags updated, accumulator kept, skip if not equal
// - IO bit test skips on low/high, no flags
// - Memory bit test skips on low/high, no flags
// - Increment, write back, flags, skip on zero
// - Decrement, write back, flags, skip on zero
// - Call pushes pc+1, jumps anywhere, sp += 2
// - Jump loads any program address, flags kept
// - Return-with-value loads accumulator, then returns
// - Return: sp -= 2, pc from stack
// - Interrupt return re-enables global interrupts after
// - Computed jump: pc becomes pc plus accumulator
// - Global-on lets interrupt requests reach CPU
// - Global-off blocks all interrupt requests
// - System halt stops all clocks
// - CPU halt gates CPU clock, oscillators run
// - Software reset behaves like hardware reset
// - Watchdog clear restarts count, flags kept
// - Branches, calls, returns, indexed move take two cycles
// - Conditional skips take two cycles when taken
// - Bit-addressed memory limited to 0x00..0x3F
package ssc_pkg;
	localparam int PC_W       = 11;
	localparam int DATA_W     = 8;
	localparam int DMEM_DEPTH = 128;
	localparam int DADDR_W    = 7;
	localparam int BIT_ADDR_W = 6;
	localparam int IO_NUM     = 32;
	localparam int IO_AW      = 5;
	localparam int BITN_W     = 3;
	localparam int SP_W       = 8;
	localparam logic [PC_W-1:0]   PC_RST    = 11'h000;
	localparam logic [PC_W-1:0]   PC_ONE    = 11'h001;
	localparam logic [SP_W-1:0]   SP_RST    = 8'h00;
	localparam logic [SP_W-1:0]   SP_STEP   = 8'h02;
	localparam logic [SP_W-1:0]   SP_ONE    = 8'h01;
	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [DATA_W-1:0] BYTE_ONE  = 8'h01;
	localparam logic [DATA_W-1:0] BYTE_FULL = 8'hFF;
	localparam int RET_HI_W = PC_W - DATA_W;

	typedef enum logic [4:0] {
		op_nop, op_bit_clear_op, op_bit_force_high_op, op_cmp_eq, op_cmp_ne,
		op_test_low_skip_io, op_test_high_skip_io, op_test_low_skip_m, op_test_high_skip_m,
		op_inc_skip_zero, op_dec_skip_zero, op_call, op_jump, op_ret_value, op_ret,
		op_ret_int, op_pc_add, op_gie_on, op_gie_off, op_sys_stop, op_cpu_stop,
		op_soft_reset, op_wdt_clear, op_index_move, op_other
	} ssc_op_t;

	// One decoded instruction as handed over by the fetch stage
	typedef struct packed {
		ssc_op_t              op;
		logic                 use_mem;  // Memory operand instead of immediate/accumulator
		logic [DATA_W-1:0]    imm;
		logic [DADDR_W-1:0]   maddr;
		logic [BITN_W-1:0]    bitn;
		logic [IO_AW-1:0]     ioaddr;
		logic [PC_W-1:0]      target;
	} ssc_instr_t;

	typedef struct packed {
		logic z;
		logic c;
		logic auxiliary_carry_flag;
		logic overflow_flag;
	} ssc_flags_t;

	typedef struct packed {
		logic [DATA_W-1:0] res;
		ssc_flags_t        fl;
	} ssc_alu_t;

	typedef enum logic [1:0] {pend_none, pend_call_hi, pend_ret_int} ssc_pend_t;

	// Add or subtract with borrow-style carries, as the core's ALU flags them
	function automatic ssc_alu_t ssc_arith(input logic [DATA_W-1:0] a,
		input logic [DATA_W-1:0] b, input logic sub);
		ssc_alu_t          r;
		logic [DATA_W:0]   full;
		logic [4:0]        nib;
		logic [DATA_W-1:0] bb;
		bb   = sub ? ~b : b;
		full = {1'b0, a} + {1'b0, bb} + {8'h00, sub};
		nib  = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
		r.res = full[DATA_W-1:0];
		r.fl.z = (full[DATA_W-1:0] == BYTE_ZERO);
		r.fl.c = sub ? ~full[DATA_W] : full[DATA_W];
		r.fl.auxiliary_carry_flag = sub ? ~nib[4] : nib[4];
		r.fl.overflow_flag = (a[DATA_W-1] == bb[DATA_W-1]) && (full[DATA_W-1] != a[DATA_W-1]);
		return r;
	endfunction

	function automatic logic [DATA_W-1:0] ssc_bit_mask(input logic [BITN_W-1:0] n);
		return BYTE_ONE << n;
	endfunction
endpackage

/* File: verification/test_ssc_core.sv */
// Self-checking bench for the skip, branch and system-control execution unit
`timescale 1ns/1ps
`define CHK(g, x) begin check_count++; if ((g) !== (x)) begin err_total++; \
	$display("[FAIL] %0t got %0h expected %0h", $time, g, x); end end
module test_ssc_core;
	import ssc_pkg::*;
	logic                   clk, rst, wake_pin;
	ssc_instr_t             instr, w;
	logic [IO_NUM-1:0][7:0] io_regs;
	logic [PC_W-1:0]        pc_r, p;
	logic [DATA_W-1:0]      acc_r, a, b;
	ssc_flags_t             flags_r, f;
	logic [SP_W-1:0]        sp_r, s;
	logic                   gie_r, sys_halt_r, cpu_halt_r, osc_run_r, chip_reset_req_r, wdt_clear_r;
	ssc_alu_t               e;
	logic [2:0]             n;
	int                     err_total, check_count, cyc;
	ssc_op_t                rops [3] = '{op_ret_value, op_ret, op_ret_int};

	ssc_core i_dut (.clk(clk), .rst(rst), .instr(instr), .io_regs(io_regs), .wake_pin(wake_pin),
		.pc_r(pc_r), .acc_r(acc_r), .flags_r(flags_r), .sp_r(sp_r), .gie_r(gie_r),
		.sys_halt_r(sys_halt_r), .cpu_halt_r(cpu_halt_r), .osc_run_r(osc_run_r),
		.chip_reset_req_r(chip_reset_req_r), .wdt_clear_r(wdt_clear_r));

	// Free-running 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Hang guard, well above the few hundred cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			$display("[FAIL] %0t run did not finish", $time);
			summarize();
		end
	end

	// Expected arithmetic, carries read as borrows on subtraction
	function automatic ssc_alu_t ref_arith(input logic [7:0] x, input logic [7:0] y, input logic sb);
		ssc_alu_t r;
		r.res = sb ? x - y : x + y;
		r.fl.z = (r.res == 8'h00);
		r.fl.c = sb ? (x < y) : ({1'b0, x} + {1'b0, y} > 9'h0FF);
		r.fl.auxiliary_carry_flag = sb ? (x[3:0] < y[3:0]) : ({1'b0, x[3:0]} + y[3:0] > 5'h0F);
		r.fl.overflow_flag = (x[7] != (y[7] ^ sb)) ? 1'b0 : (r.res[7] != x[7]);
		return r;
	endfunction

	function automatic ssc_instr_t mk(input ssc_op_t op);
		ssc_instr_t i;
		i = '0;
		i.op = op;
		return i;
	endfunction

	// One instruction slot, driven just after the edge
	task automatic run(input ssc_instr_t i);
		instr = i;
		@(posedge clk);
		#1;
	endtask

	// Accumulator set through a call and a return-with-value
	task automatic load_acc(input logic [7:0] v);
		w = mk(op_call);
		w.target = 11'h100;
		run(w);
		run(mk(op_nop));
		w = mk(op_ret_value);
		w.imm = v;
		run(w);
		run(mk(op_nop));
	endtask

	// A side-effect op sits in the slot after the skip to prove it is dropped
	task automatic skip_chk(input ssc_instr_t i, input logic tk, input ssc_flags_t ef);
		p = pc_r;
		run(i);
		`CHK(flags_r, ef)
		run(mk(op_gie_on));
		`CHK(pc_r, p + 11'h002)
		`CHK(gie_r, ~tk)
		run(mk(op_gie_off));
		`CHK(gie_r, 1'b0)
	endtask

	task automatic chk_reset();
		`CHK({pc_r, acc_r, flags_r, sp_r}, 31'h0)
		`CHK({gie_r, sys_halt_r, cpu_halt_r, osc_run_r, chip_reset_req_r, wdt_clear_r}, 6'h04)
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		void'($urandom(32'hA229));
		err_total = 0;
		check_count = 0;
		cyc = 0;
		rst = 1'b1;
		wake_pin = 1'b0;
		io_regs = '0;
		instr = mk(op_nop);
		repeat (10) @(posedge clk);
		#1 rst = 1'b0;
		chk_reset();
		// Calls with every return kind; dropped slots carry side-effect ops
		for (int k = 0; k < 6; k++) begin
			p = pc_r; s = sp_r; a = 8'($urandom); b = acc_r; f = flags_r;
			w = mk(op_call);
			w.target = 11'($urandom);
			run(w);
			run(mk(op_gie_on));
			`CHK(pc_r, w.target)
			`CHK(sp_r, s + SP_STEP)
			`CHK(gie_r, 1'b0)
			w = mk(rops[k % 3]);
			w.imm = a;
			run(w);
			run(mk(op_wdt_clear));
			`CHK({pc_r, sp_r, flags_r}, {p + PC_ONE, s, f})
			`CHK(acc_r, (rops[k % 3] == op_ret_value) ? a : b)
			`CHK(gie_r, rops[k % 3] == op_ret_int)
			`CHK(wdt_clear_r, 1'b0)
			run(mk(op_gie_off));
		end
		$display("call and return done");
		// Compares, equal and unequal, with boundary operands
		for (int k = 0; k < 8; k++) begin
			a = (k == 0) ? 8'h80 : 8'($urandom);
			b = k[0] ? a : ((k == 2) ? 8'h7F : 8'($urandom));
			load_acc(a);
			w = mk(op_cmp_eq);
			w.imm = b;
			e = ref_arith(a, b, 1'b1);
			skip_chk(w, a == b, e.fl);
			w.op = op_cmp_ne;
			skip_chk(w, a != b, e.fl);
			`CHK(acc_r, a)
		end
		$display("compare skip done");
		// IO bit tests on random register contents
		for (int k = 0; k < 10; k++) begin
			for (int j = 0; j < IO_NUM; j++) io_regs[j] = 8'($urandom);
			w = mk(op_test_low_skip_io);
			if (k[0]) w.op = op_test_high_skip_io;
			w.ioaddr = 5'($urandom);
			w.bitn = 3'($urandom);
			skip_chk(w, io_regs[w.ioaddr][w.bitn] == k[0], flags_r);
		end
		$display("io bit test done");
		// Memory bits: clear a byte, force one bit, test all eight, then count down
		for (int k = 0; k < 4; k++) begin
			w = mk(op_bit_clear_op);
			w.maddr = (k[0] ? 7'h60 : 7'h20) | 7'($urandom % 32);
			n = (k == 0) ? 3'h0 : 3'($urandom);
			for (int j = 0; j < 8; j++) begin
				w.bitn = 3'(j);
				run(w);
			end
			f = flags_r;
			w.op = op_bit_force_high_op;
			w.bitn = n;
			run(w);
			`CHK(flags_r, f)
			for (int j = 0; j < 8; j++) begin
				w.bitn = 3'(j);
				w.op = op_test_high_skip_m;
				skip_chk(w, j == n, f);
				w.op = op_test_low_skip_m;
				skip_chk(w, j != n, f);
			end
			w.op = op_dec_skip_zero;
			w.use_mem = 1'b1;
			w.maddr[6] = 1'b0;
			e = ref_arith(8'h01 << n, 8'h01, 1'b1);
			skip_chk(w, e.fl.z, e.fl);
			e = ref_arith(e.res, 8'h01, 1'b1);
			skip_chk(w, e.fl.z, e.fl);
		end
		$display("memory bit done");
		// Accumulator increment and decrement across wrap points
		for (int k = 0; k < 6; k++) begin
			a = (k == 0) ? 8'hFF : ((k == 1) ? 8'h7F : ((k == 2) ? 8'h01 : 8'($urandom)));
			load_acc(a);
			e = ref_arith(a, 8'h01, 1'b0);
			skip_chk(mk(op_inc_skip_zero), e.fl.z, e.fl);
			`CHK(acc_r, e.res)
			e = ref_arith(e.res, 8'h01, 1'b1);
			skip_chk(mk(op_dec_skip_zero), e.fl.z, e.fl);
			`CHK(acc_r, e.res)
		end
		$display("increment decrement done");
		// Computed and plain jumps, with the second slot dropped
		for (int k = 0; k < 4; k++) begin
			a = 8'($urandom);
			load_acc(a);
			f = flags_r;
			p = pc_r;
			run(mk(op_pc_add));
			run(mk(op_gie_on));
			`CHK(pc_r, p + {3'b000, a})
			w = mk(op_jump);
			w.target = 11'($urandom);
			run(w);
			run(mk(op_gie_on));
			`CHK({pc_r, gie_r, flags_r}, {w.target, 1'b0, f})
			p = pc_r;
			run(mk(op_index_move));
			run(mk(op_gie_on));
			`CHK({pc_r, gie_r}, {p + PC_ONE, 1'b0})
		end
		f = flags_r;
		run(mk(op_wdt_clear));
		`CHK(wdt_clear_r, 1'b1)
		run(mk(op_nop));
		`CHK({wdt_clear_r, flags_r}, {1'b0, f})
		$display("jump and watchdog done");
		// CPU halt then system halt, each left by the wake pin
		for (int k = 0; k < 2; k++) begin
			p = pc_r;
			run(mk(k ? op_sys_stop : op_cpu_stop));
			run(mk(op_gie_on));
			`CHK({cpu_halt_r, sys_halt_r, osc_run_r}, {1'b1, k[0], ~k[0]})
			`CHK({pc_r, gie_r}, {p + PC_ONE, 1'b0})
			instr = mk(op_nop);
			wake_pin = 1'b1;
			for (int j = 0; j < 10 && cpu_halt_r !== 1'b0; j++) begin
				@(posedge clk);
				#1;
			end
			wake_pin = 1'b0;
			// Let the wake synchroniser drain so the next halt is not left at once
			repeat (2) @(posedge clk);
			#1;
			`CHK({cpu_halt_r, sys_halt_r, osc_run_r}, 3'b001)
		end
		$display("halt done");
		run(mk(op_soft_reset));
		run(mk(op_gie_on));
		`CHK({chip_reset_req_r, gie_r}, 2'b10)
		rst = 1'b1;
		@(posedge clk);
		#1 rst = 1'b0;
		chk_reset();
		$display("software reset done");
		summarize();
	end
endmodule
